// ==== dv/sdram_command_timing_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdram_command_timing_chk #(
   parameter int INIT_WAIT = 20
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Command and data lines
   input wire logic        cs_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic        cke,
   input wire logic [12:0] addr,
   input wire logic        dqm,
   input wire logic        dq_ctl_oe,
   input wire logic        dq_mem_oe
);
   import sdram_timing_pkg::*;
   // Decoded link commands
   wire logic [3:0] cmd    = {cs_n, ras_n, cas_n, we_n};
   wire logic       is_act = cmd == CMD_ACTIVE;
   wire logic       is_rd  = cmd == CMD_READ;
   wire logic       is_wr  = cmd == CMD_WRITE;
   wire logic       is_pre = cmd == CMD_PRECHARGE;
   wire logic       is_ref = cmd == CMD_REFRESH;
   wire logic       is_mrs = cmd == CMD_MODE_LOAD;
   logic            ap_wr;
   logic [15:0]     since;
   // Auto-precharge flag of last write, cycles since reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ap_wr <= 1'b0;
         since <= 16'h0;
      end else begin
         if (is_wr) ap_wr <= addr[10];
         if (since != 16'hffff) since <= since + 16'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_write_data_along: assert property (is_wr |-> dq_ctl_oe)
      else $error("write without data");
   a_read_no_drive: assert property (is_rd |-> !dq_ctl_oe)
      else $error("controller drives during read");
   a_mode_load_gap: assert property (is_mrs |=> !(is_act || is_ref) [*3])
      else $error("activate or refresh too soon after mode load");
   a_precharge_after_data: assert property ($fell(dq_ctl_oe) |-> !is_pre ##1 !is_pre)
      else $error("precharge too soon after write data");
   a_ap_activate_gap: assert property ($fell(dq_ctl_oe) && ap_wr |-> !is_act [*5])
      else $error("activate too soon after auto-precharge write");
   a_read_mask_float: assert property (dqm |-> ##3 !dq_mem_oe)
      else $error("masked read data still driven");
   a_precharge_float: assert property (is_pre |-> ##3 !dq_mem_oe)
      else $error("read data not floated after precharge");
   a_init_wait_done: assert property (is_act |-> since > INIT_WAIT)
      else $error("activate before power-up wait");
   // Main scenarios
   c_back_writes: cover property (is_wr ##1 is_wr);
   c_read_data: cover property (is_rd ##[1:6] dq_mem_oe);
   c_suspend: cover property ($fell(cke));
endmodule : sdram_command_timing_chk
`default_nettype wire

// ==== dv/sdram_command_timing_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module sdram_command_timing_tb;
   import sdram_timing_pkg::*;
   localparam int INIT_WAIT = 20;
   localparam int REF_GAP   = 300;
   localparam int AP_GAP    = 5;
   logic        clk;
   logic        rst_n;
   logic        req_valid;
   cmd_t        req_cmd;
   logic [12:0] req_addr;
   logic [1:0]  req_bank;
   logic [15:0] req_wdata;
   logic        req_dqm;
   logic        req_last_wdata;
   logic        req_cke;
   logic        req_ready;
   logic        init_done;
   logic        suspended;
   logic        ready;
   logic        ap_pending;
   logic        ap_seen;
   int          err_count;
   int          total_checks;
   int          cyc;
   int          ref_count;
   int          at [16];
   logic [15:0] rd_q [$];
   sdram_link_if link ();
   sdram_controller_end #(.INIT_WAIT(INIT_WAIT), .REFRESH_GAP(REF_GAP), .AP_GAP(AP_GAP))
      sdram_controller_end_inst (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_cmd(req_cmd),
      .req_addr(req_addr), .req_bank(req_bank), .req_wdata(req_wdata), .req_dqm(req_dqm),
      .req_last_wdata(req_last_wdata), .req_cke(req_cke), .req_ready(req_ready), .init_done(init_done),
      .link(link));
   sdram_memory_end sdram_memory_end_inst (.clk(clk),
      .rst_n(rst_n), .link(link), .suspended(suspended), .ready(ready), .ap_pending(ap_pending));
   sdram_command_timing_chk #(.INIT_WAIT(INIT_WAIT)) sdram_command_timing_chk_inst (.clk(clk),
      .rst_n(rst_n), .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
      .cke(link.cke), .addr(link.addr), .dqm(link.dqm), .dq_ctl_oe(link.dq_ctl_oe),
      .dq_mem_oe(link.dq_mem_oe));
   // Clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Command stamps, refresh count, read capture
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (link.cs_n === 1'b0) at[{link.cs_n, link.ras_n, link.cas_n, link.we_n}] <= cyc;
      if ({link.cs_n, link.ras_n, link.cas_n, link.we_n} === CMD_REFRESH) ref_count <= ref_count + 1;
      if (link.dq_mem_oe === 1'b1) rd_q.push_back(link.dq);
      if (ap_pending === 1'b1) ap_seen <= 1'b1;
   end
   // One request, held until taken; entered and left at a rising edge
   task automatic issue(input cmd_t c, input logic [12:0] a, input logic [15:0] d, input logic m);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req_cmd <= c;
      req_addr <= a;
      req_wdata <= d;
      req_dqm <= m;
      req_last_wdata <= (c == CMD_WRITE);
      do begin
         @(negedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 2000);
      @(posedge clk);
   endtask : issue
   task automatic idle(input int k);
      req_valid <= 1'b0;
      repeat (k) @(posedge clk);
   endtask : idle
   task automatic t_init();
      @(negedge clk);
      `CHK(init_done, 1'b0)
      `CHK(ready, 1'b0)
      while (init_done !== 1'b1 && cyc < 800) @(negedge clk);
      `CHK(ready, 1'b1)
      `CHK(ref_count >= 2, 1'b1)
      @(posedge clk);
   endtask : t_init
   task automatic t_mode();
      issue(CMD_MODE_LOAD, 13'h020, 16'h0, 1'b0);
      issue(CMD_ACTIVE, 13'h010, 16'h0, 1'b0);
      idle(4);
      `CHK(at[CMD_ACTIVE] - at[CMD_MODE_LOAD] >= 4, 1'b1)
   endtask : t_mode
   task automatic t_wr_rd();
      issue(CMD_WRITE, 13'h005, 16'ha5c3, 1'b0);
      issue(CMD_WRITE, 13'h006, 16'h0f0f, 1'b0);
      issue(CMD_WRITE, 13'h006, 16'hffff, 1'b1);
      idle(3);
      rd_q.delete();
      issue(CMD_READ, 13'h005, 16'h0, 1'b0);
      issue(CMD_READ, 13'h006, 16'h0, 1'b0);
      idle(8);
      `CHK(rd_q.size(), 2)
      `CHK(rd_q[0], 16'ha5c3)
      `CHK(rd_q[1], 16'h0f0f)
   endtask : t_wr_rd
   task automatic t_mask();
      rd_q.delete();
      issue(CMD_READ, 13'h005, 16'h0, 1'b1);
      idle(8);
      `CHK(rd_q.size(), 0)
   endtask : t_mask
   // Precharge cuts a four-beat read, the beat in flight still leaves
   task automatic t_float();
      issue(CMD_MODE_LOAD, 13'h022, 16'h0, 1'b0);
      rd_q.delete();
      issue(CMD_READ, 13'h005, 16'h0, 1'b0);
      issue(CMD_PRECHARGE, 13'h400, 16'h0, 1'b0);
      idle(8);
      `CHK(rd_q.size(), 1)
      `CHK(rd_q[0], 16'ha5c3)
      issue(CMD_MODE_LOAD, 13'h020, 16'h0, 1'b0);
   endtask : t_float
   task automatic t_gaps();
      issue(CMD_WRITE, 13'h007, 16'h3c3c, 1'b0);
      issue(CMD_PRECHARGE, 13'h000, 16'h0, 1'b0);
      idle(4);
      `CHK(at[CMD_PRECHARGE] - at[CMD_WRITE] >= 3, 1'b1)
      ap_seen <= 1'b0;
      issue(CMD_ACTIVE, 13'h010, 16'h0, 1'b0);
      issue(CMD_WRITE, 13'h408, 16'h5a5a, 1'b0);
      issue(CMD_ACTIVE, 13'h010, 16'h0, 1'b0);
      idle(4);
      `CHK(at[CMD_ACTIVE] - at[CMD_WRITE] >= AP_GAP + 1, 1'b1)
      `CHK(ap_seen, 1'b1)
   endtask : t_gaps
   task automatic t_suspend();
      req_cke <= 1'b0;
      repeat (4) @(negedge clk);
      `CHK(suspended, 1'b1)
      @(posedge clk);
      req_cke <= 1'b1;
      repeat (4) @(negedge clk);
      `CHK(suspended, 1'b0)
      @(posedge clk);
      rd_q.delete();
      issue(CMD_READ, 13'h008, 16'h0, 1'b0);
      idle(8);
      `CHK(rd_q[0], 16'h5a5a)
   endtask : t_suspend
   task automatic t_refresh();
      int n0;
      n0 = ref_count;
      idle(REF_GAP + 60);
      `CHK(ref_count - n0 >= 2, 1'b1)
      `CHK(ready, 1'b1)
   endtask : t_refresh
   task automatic summarize();
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize
   // Watchdog
   initial begin
      repeat (6000) @(posedge clk);
      err_count++;
      summarize();
   end
   // Reset and scenario sequence
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_cmd = CMD_NOP;
      req_addr = 13'h0;
      req_bank = 2'h0;
      req_wdata = 16'h0;
      req_dqm = 1'b0;
      req_last_wdata = 1'b0;
      req_cke = 1'b1;
      ap_seen = 1'b0;
      err_count = 0;
      total_checks = 0;
      cyc = 0;
      ref_count = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_init();
      t_mode();
      t_wr_rd();
      t_mask();
      t_float();
      t_gaps();
      t_suspend();
      t_refresh();
      summarize();
   end
endmodule : sdram_command_timing_tb
`default_nettype wire

// ==== hw/sdram_controller_end.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sdram_timing_cfg.svh"
module sdram_controller_end #(
   parameter int AW          = 13,
   parameter int DW          = 16,
   parameter int INIT_WAIT   = `INIT_WAIT_CYCLES,
   parameter int REFRESH_GAP = `REFRESH_INTERVAL_CYCLES,
   parameter int AP_GAP      = `WRITE_TO_ACTIVATE_GAP
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // User request
   input  wire logic                  req_valid,
   input  wire sdram_timing_pkg::cmd_t req_cmd,
   input  wire logic [AW-1:0]         req_addr,
   input  wire logic [1:0]            req_bank,
   input  wire logic [DW-1:0]         req_wdata,
   input  wire logic                  req_dqm,
   input  wire logic                  req_last_wdata,
   input  wire logic                  req_cke,
   output var  logic                  req_ready,
   output var  logic                  init_done,
   // Link
   sdram_link_if.controller           link
);
   import sdram_timing_pkg::*;

   typedef enum {ST_WAIT, ST_PRE, ST_REF1, ST_REF2, ST_MODE, ST_RUN} init_t;
   init_t state;
   init_t next_state;
   logic [31:0] wait_cnt;
   logic [31:0] refresh_cnt;
   logic [3:0]  gap_cnt;
   logic [3:0]  next_gap;

   // Gap demanded before next command, plus register stage except for column spacing
   wire logic [3:0] stage = 4'(`REGISTER_STAGE);
   wire logic [3:0] gap_for_req =
      (req_cmd == CMD_MODE_LOAD) ? 4'(`MODE_LOAD_GAP) + stage :
      (req_last_wdata && req_cmd == CMD_WRITE && req_addr[10]) ? 4'(AP_GAP) + stage :
      (req_last_wdata && req_cmd == CMD_WRITE) ? 4'(`WRITE_TO_PRECHARGE_GAP) + stage :
      4'(`COLUMN_CMD_SPACING);
   wire logic ok_run = (state == ST_RUN) && (gap_cnt == 4'h0) && (refresh_cnt != 32'h0);
   wire logic take   = ok_run && req_valid;
   wire logic seq_go = (gap_cnt == 4'h0) && (wait_cnt == 32'h0);

   // Init sequence
   always_comb begin
      next_state = state;
      case (state)
         ST_WAIT: if (seq_go) next_state = ST_PRE;
         ST_PRE:  if (seq_go) next_state = ST_REF1;
         ST_REF1: if (seq_go) next_state = ST_REF2;
         ST_REF2: if (seq_go) next_state = ST_MODE;
         ST_MODE: if (seq_go) next_state = ST_RUN;
         ST_RUN:  if (refresh_cnt == 32'h0 && gap_cnt == 4'h0) next_state = ST_REF1;
         default: next_state = ST_WAIT;
      endcase
   end
   always_comb begin
      next_gap = (gap_cnt != 4'h0) ? gap_cnt - 4'h1 : 4'h0;
      if (take) next_gap = gap_for_req - 4'h1;
      else if (seq_go && state != ST_RUN && state != ST_WAIT) next_gap = 4'(`MODE_LOAD_GAP) + stage;
   end
   // Refresh timer, reloaded when a refresh run starts
   wire logic [31:0] next_refresh = (next_state == ST_REF1 && state != ST_REF1) ? 32'(REFRESH_GAP) :
      (refresh_cnt != 32'h0 && state == ST_RUN) ? refresh_cnt - 32'h1 : refresh_cnt;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state       <= ST_WAIT;
         wait_cnt    <= 32'(INIT_WAIT);
         refresh_cnt <= 32'(REFRESH_GAP);
         gap_cnt     <= 4'h0;
      end else begin
         state       <= next_state;
         gap_cnt     <= next_gap;
         wait_cnt    <= (wait_cnt != 32'h0) ? wait_cnt - 32'h1 : 32'h0;
         refresh_cnt <= next_refresh;
      end
   end

   // Command output, constant clock, slowed by clock enable only
   wire cmd_t seq_cmd = (state == ST_PRE)  ? CMD_PRECHARGE :
                        (state == ST_REF1 || state == ST_REF2) ? CMD_REFRESH :
                        (state == ST_MODE) ? CMD_MODE_LOAD : CMD_NOP;
   wire cmd_t out_cmd = take ? req_cmd : ((seq_go && state != ST_RUN) ? seq_cmd : CMD_NOP);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'h7;
         link.cke       <= 1'b1;
         link.addr      <= '0;
         link.bank      <= 2'h0;
         link.dqm       <= 1'b1;
         link.dq_ctl    <= '0;
         link.dq_ctl_oe <= 1'b0;
         req_ready      <= 1'b0;
         init_done      <= 1'b0;
      end else begin
         {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= out_cmd;
         link.cke       <= (state == ST_RUN) ? req_cke : 1'b1;
         link.addr      <= take ? req_addr : ((state == ST_PRE) ? AW'(1 << 10) : AW'(8'h20));
         link.bank      <= take ? req_bank : 2'h0;
         link.dqm       <= take ? req_dqm : 1'b0;
         link.dq_ctl    <= req_wdata;
         link.dq_ctl_oe <= take && (req_cmd == CMD_WRITE);
         req_ready      <= (next_state == ST_RUN) && (next_gap == 4'h0) && (next_refresh != 32'h0);
         init_done      <= (next_state == ST_RUN);
      end
   end
endmodule : sdram_controller_end
`default_nettype wire

// ==== hw/sdram_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sdram_link_if #(parameter int DW = 16, parameter int AW = 13);
   logic          cs_n;
   logic          ras_n;
   logic          cas_n;
   logic          we_n;
   logic          cke;
   logic [AW-1:0] addr;
   logic [1:0]    bank;
   logic          dqm;
   logic [DW-1:0] dq_ctl;
   logic          dq_ctl_oe;
   logic [DW-1:0] dq_mem;
   logic          dq_mem_oe;
   wire  [DW-1:0] dq = dq_mem_oe ? dq_mem : dq_ctl;
   modport memory (input cs_n, ras_n, cas_n, we_n, cke, addr, bank, dqm, dq_ctl, dq_ctl_oe,
                   output dq_mem, dq_mem_oe);
   modport controller (output cs_n, ras_n, cas_n, we_n, cke, addr, bank, dqm, dq_ctl, dq_ctl_oe,
                       input dq_mem, dq_mem_oe);
endinterface : sdram_link_if
`default_nettype wire

// ==== hw/sdram_memory_end.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sdram_timing_cfg.svh"
// How it works
// - Column commands may come every clock
// - Low clock enable suspends one clock later
// - High clock enable resumes one clock later
// - Write mask blocks same-cycle data
// - Read mask floats data two clocks later
// - First write data rides with command
// - Auto-precharge write waits 5/4 before activate
// - Two clocks from last data to precharge
// - Burst stop one clock after data
// - New column command one clock after data
// - Mode load needs two clocks before activate
// - Three clocks preferred after mode load
// - Precharge floats read data after CAS latency
// - Wait 100 us, two refreshes first
// - Repeat wake-up refreshes after missed refresh
// - Clock stays constant during accesses
// - Use clock enable to slow data
// - Auto precharge starts after 7.5 ns
// - Registered inputs add one clock
// - Refresh 8192 rows within 64 ms
module sdram_memory_end #(
   parameter int DW    = 16,
   parameter int AW    = 13,
   parameter int COLW  = 9,
   parameter int DEPTH = 64
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Link
   sdram_link_if.memory       link,
   // Status
   output var  logic          suspended,
   output var  logic          ready,
   output var  logic          ap_pending
);
   import sdram_timing_pkg::*;

   // Input register stage, the extra clock
   logic          r_cke;
   logic [3:0]    r_cmd;
   logic [AW-1:0] r_addr;
   logic [1:0]    r_bank;
   logic          r_dqm;
   logic [DW-1:0] r_din;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_cke  <= 1'b0;
         r_cmd  <= 4'h7;
         r_addr <= '0;
         r_bank <= '0;
         r_dqm  <= 1'b1;
         r_din  <= '0;
      end else begin
         r_cke  <= link.cke;
         r_cmd  <= {link.cs_n, link.ras_n, link.cas_n, link.we_n};
         r_addr <= link.addr;
         r_bank <= link.bank;
         r_dqm  <= link.dqm;
         r_din  <= link.dq_ctl;
      end
   end

   // Clock enable seen last cycle gates this cycle
   logic cke_prev;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cke_prev <= 1'b0;
      else        cke_prev <= r_cke;
   end
   wire logic run = cke_prev;

   // Command decode
   wire cmd_t cmd         = cmd_t'(r_cmd);
   wire logic is_active   = run && (cmd == CMD_ACTIVE);
   wire logic is_read     = run && (cmd == CMD_READ);
   wire logic is_write    = run && (cmd == CMD_WRITE);
   wire logic is_stop     = run && (cmd == CMD_STOP);
   wire logic is_pre      = run && (cmd == CMD_PRECHARGE);
   wire logic is_refresh  = run && (cmd == CMD_REFRESH) && r_cke;
   wire logic is_mode     = run && (cmd == CMD_MODE_LOAD);

   // Mode register fields
   logic [2:0] burst_code;
   logic [1:0] cas_lat;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         burst_code <= 3'h0;
         cas_lat    <= 2'h3;
      end else if (is_mode) begin
         burst_code <= r_addr[2:0];
         cas_lat    <= (r_addr[6:4] == 3'h2) ? 2'h2 : 2'h3;
      end
   end
   wire logic [3:0] burst_len = (burst_code == 3'h0) ? 4'h1 :
                                (burst_code == 3'h1) ? 4'h2 :
                                (burst_code == 3'h2) ? 4'h4 : 4'h8;

   // Wake-up refresh counter
   logic [1:0] wake_refreshes;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         wake_refreshes <= 2'h0;
      else if (is_refresh && wake_refreshes != 2'(`INIT_REFRESH_COUNT))
         wake_refreshes <= wake_refreshes + 2'h1;
   end

   // Storage and row state per bank
   logic [DW-1:0] mem [DEPTH];
   logic [AW-1:0] open_row [4];
   logic [COLW-1:0] col;
   logic [1:0]    burst_bank;
   logic [3:0]    burst_left;
   logic          burst_wr;
   logic          burst_ap;
   wire  logic    col_cmd    = is_read || is_write;
   wire  logic    burst_live = (burst_left != 4'h0) && run;
   wire  logic [COLW-1:0] cur_col = col_cmd ? r_addr[COLW-1:0] : col;
   wire  logic [1:0]      cur_bank = col_cmd ? r_bank : burst_bank;
   wire  logic            cur_wr = col_cmd ? is_write : burst_wr;
   wire  logic            beat = col_cmd || burst_live;
   localparam int IW = $clog2(DEPTH);
   wire  logic [IW-1:0]   idx = IW'({open_row[cur_bank], cur_bank, cur_col});

   // Burst sequencer; new column command cuts the old burst
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         col        <= '0;
         burst_bank <= 2'h0;
         burst_left <= 4'h0;
         burst_wr   <= 1'b0;
         burst_ap   <= 1'b0;
      end else if (col_cmd) begin
         col        <= r_addr[COLW-1:0] + COLW'(1);
         burst_bank <= r_bank;
         burst_left <= burst_len - 4'h1;
         burst_wr   <= is_write;
         burst_ap   <= r_addr[10];
      end else if (is_stop || is_pre) begin
         burst_left <= 4'h0;
      end else if (burst_live) begin
         col        <= col + COLW'(1);
         burst_left <= burst_left - 4'h1;
      end
   end

   // Open rows
   always_ff @(posedge clk) begin
      if (is_active)
         open_row[r_bank] <= r_addr;
   end

   // Write path, data with the command, masked same cycle
   always_ff @(posedge clk) begin
      if (beat && cur_wr && !r_dqm)
         mem[idx] <= r_din;
   end

   // Auto-precharge settle after last write beat
   logic [3:0] ap_count;
   wire  logic cur_ap       = col_cmd ? r_addr[10] : burst_ap;
   wire  logic cur_last     = col_cmd ? (burst_len == 4'h1) : (burst_left == 4'h1);
   wire  logic last_wr_beat = beat && cur_wr && cur_ap && cur_last;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         ap_count <= 4'h0;
      else if (last_wr_beat)
         ap_count <= 4'(1 + `AP_SETTLE_CYCLES);
      else if (ap_count != 4'h0)
         ap_count <= ap_count - 4'h1;
   end

   // Read pipeline, length set by CAS latency
   logic [DW-1:0] rd_data [3];
   logic [2:0]    rd_valid;
   // Precharge drops the beat of its own cycle; beats in flight still leave
   wire  logic    rd_beat = beat && !cur_wr && !is_pre;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid <= 3'h0;
      end else if (run) begin
         rd_valid <= {rd_valid[1:0], rd_beat};
      end
   end
   always_ff @(posedge clk) begin
      if (run) begin
         rd_data[0] <= mem[idx];
         rd_data[1] <= rd_data[0];
         rd_data[2] <= rd_data[1];
      end
   end
   wire logic [1:0] tap = (cas_lat == 2'h2) ? 2'h0 : 2'h1;

   // Read mask, one stage here plus the output register
   logic mask_pipe;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) mask_pipe <= 1'b1;
      else        mask_pipe <= r_dqm;
   end

   // Output drive
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link.dq_mem    <= '0;
         link.dq_mem_oe <= 1'b0;
      end else begin
         link.dq_mem    <= rd_data[tap];
         link.dq_mem_oe <= rd_valid[tap] && !mask_pipe;
      end
   end

   // Status flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         suspended  <= 1'b1;
         ready      <= 1'b0;
         ap_pending <= 1'b0;
      end else begin
         suspended  <= !r_cke;
         ready      <= (wake_refreshes == 2'(`INIT_REFRESH_COUNT));
         ap_pending <= (ap_count != 4'h0);
      end
   end
endmodule : sdram_memory_end
`default_nettype wire

// ==== hw/sdram_timing_cfg.svh ====
`ifndef SDRAM_TIMING_CFG_SVH
`define SDRAM_TIMING_CFG_SVH
// Cycle counts between commands
`define COLUMN_CMD_SPACING        1
`define SUSPEND_ENTRY_DELAY       1
`define SUSPEND_EXIT_DELAY        1
`define WRITE_MASK_LATENCY        0
`define READ_MASK_FLOAT_LATENCY   2
`define WRITE_DATA_DELAY          0
`define WRITE_TO_ACTIVATE_GAP     5
`define WRITE_TO_ACTIVATE_GAP_100 4
`define WRITE_TO_PRECHARGE_GAP    2
`define WRITE_TO_STOP_GAP         1
`define WRITE_TO_COLUMN_GAP       1
`define MODE_LOAD_GAP             3
`define PRECHARGE_FLOAT_CL3       3
`define PRECHARGE_FLOAT_CL2       2
`define REGISTER_STAGE            1
// Power-up wait
`define INIT_WAIT_US              100
`define CLK_MHZ                   25
`define INIT_WAIT_CYCLES          (`INIT_WAIT_US * `CLK_MHZ)
`define INIT_REFRESH_COUNT        2
// Refresh: 8192 rows in 64 ms
`define REFRESH_ROWS              8192
`define REFRESH_PERIOD_MS         64
`define REFRESH_INTERVAL_CYCLES   ((`REFRESH_PERIOD_MS * 1000 * `CLK_MHZ) / `REFRESH_ROWS)
// Auto-precharge settle after write, 7.5 ns rounded up
`define AP_SETTLE_PS              7500
`define CLK_PERIOD_PS             40000
`define AP_SETTLE_CYCLES          ((`AP_SETTLE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

// ==== hw/sdram_timing_pkg.sv ====
package sdram_timing_pkg;
   // Command code {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      CMD_INHIBIT   = 4'h8,
      CMD_NOP       = 4'h7,
      CMD_ACTIVE    = 4'h3,
      CMD_READ      = 4'h5,
      CMD_WRITE     = 4'h4,
      CMD_STOP      = 4'h6,
      CMD_PRECHARGE = 4'h2,
      CMD_REFRESH   = 4'h1,
      CMD_MODE_LOAD = 4'h0
   } cmd_t;
endpackage : sdram_timing_pkg
